// ### rtl/stdi_top.sv
// Serial transmit data input: register port on clk_sys, bit clock,
// pin sampling and modulator feed on the free-running clk_link.
// Assumes software changes configuration only while idle.
module stdi_top
#(
   parameter int          CAL_CYCLES = 16,
   parameter int          HDR_BITS   = 48,
   parameter logic [47:0] HDR_WORD   = 48'hAAAAAAAAA5C3
)
(
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       clk_link,
   input  wire logic [5:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       pin_zero_in,
   output logic            pin_zero_out,
   output logic            pin_zero_oe,
   output logic            serial_clock,
   output logic            mod_data,
   output logic            synth_on,
   output logic            tx_active,
   output logic            pkt_engine_en,
   output logic            fifo_path_en,
   output logic            whiten_en,
   output logic            fec_en,
   output logic            biphase_en,
   output logic            cfg_invalid
);
   import stdi_pkg::*;

   // ----------------------------------------------------
   // Reset release, one copy per domain
   // ----------------------------------------------------
   logic [1:0] rst_sys_sr;
   logic [1:0] rst_lnk_sr;
   logic       rst_sys_n;
   logic       rst_lnk_n;

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         rst_sys_sr <= 2'h0;
      else
         rst_sys_sr <= {rst_sys_sr[0], 1'b1};
   end

   always_ff @(posedge clk_link or negedge nrst)
   begin
      if (!nrst)
         rst_lnk_sr <= 2'h0;
      else
         rst_lnk_sr <= {rst_lnk_sr[0], 1'b1};
   end

   assign rst_sys_n = rst_sys_sr[1];
   assign rst_lnk_n = rst_lnk_sr[1];

   // ----------------------------------------------------
   // Register port (clk_sys)
   // ----------------------------------------------------
   stdi_cfg_t  cfg;
   stdi_cfg_t  next_cfg;
   logic       start_tgl;
   logic       next_start_tgl;
   logic       idle_tgl;
   logic       next_idle_tgl;
   logic [7:0] next_reg_rdata;
   logic       next_cfg_invalid;
   stdi_stat_t stat_s1;
   stdi_stat_t stat_s2;
   stdi_stat_t stat_lnk;

   always_comb
   begin
      next_cfg       = cfg;
      next_start_tgl = start_tgl;
      next_idle_tgl  = idle_tgl;
      next_reg_rdata = 8'h00;
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_PKT_CTRL:
            begin
               next_cfg.layout = reg_wdata[1:0];
               next_cfg.whiten = reg_wdata[6];
               next_cfg.fec    = reg_wdata[2];
            end
            ADDR_MOD_TWO:
            begin
               next_cfg.mod_fmt = reg_wdata[6:4];
               next_cfg.biphase = reg_wdata[3];
            end
            ADDR_MOD_THR: next_cfg.frame_mode = reg_wdata[2:0];
            ADDR_RATE:    next_cfg.rate_div   = reg_wdata;
            ADDR_AUTOCAL: next_cfg.auto_cal   = reg_wdata[0];
            ADDR_COMMAND:
            begin
               if (reg_wdata == CMD_TX_START)
                  next_start_tgl = !start_tgl;
               else if (reg_wdata == CMD_IDLE)
                  next_idle_tgl = !idle_tgl;
            end
            default: ;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_PKT_CTRL:
               next_reg_rdata = {1'b0, cfg.whiten, 3'h0,
                                 cfg.fec, cfg.layout};
            ADDR_MOD_TWO:
               next_reg_rdata = {1'b0, cfg.mod_fmt,
                                 cfg.biphase, 3'h0};
            ADDR_MOD_THR: next_reg_rdata = {5'h00, cfg.frame_mode};
            ADDR_RATE:    next_reg_rdata = cfg.rate_div;
            ADDR_AUTOCAL: next_reg_rdata = {7'h00, cfg.auto_cal};
            ADDR_STATUS:
               next_reg_rdata = {4'h0, cfg_invalid, stat_s2.pin,
                                 stat_s2.state};
            default:      next_reg_rdata = 8'h00;
         endcase
      end
      // MSK cannot ride the asynchronous path
      next_cfg_invalid = (cfg.layout == LAYOUT_ASYNC) &&
                         (cfg.mod_fmt == MOD_MSK);
   end

   always_ff @(posedge clk_sys or negedge rst_sys_n)
   begin
      if (!rst_sys_n)
      begin
         cfg         <= CFG_RESET;
         start_tgl   <= 1'b0;
         idle_tgl    <= 1'b0;
         reg_rdata   <= 8'h00;
         cfg_invalid <= 1'b0;
         stat_s1     <= '0;
         stat_s2     <= '0;
      end
      else
      begin
         cfg         <= next_cfg;
         start_tgl   <= next_start_tgl;
         idle_tgl    <= next_idle_tgl;
         reg_rdata   <= next_reg_rdata;
         cfg_invalid <= next_cfg_invalid;
         stat_s1     <= stat_lnk;
         stat_s2     <= stat_s1;
      end
   end

   // ----------------------------------------------------
   // Crossings into clk_link
   // ----------------------------------------------------
   // Configuration is quasi-static, so a plain two-stage
   // sync per bit is enough; commands travel as toggles.
   stdi_cfg_t   cfg_s1;
   stdi_cfg_t   lcfg;
   logic [2:0]  start_sr;
   logic [2:0]  idle_sr;
   logic [1:0]  pin_sr;
   logic        start_ev;
   logic        idle_ev;
   logic        is_sync;
   logic        is_async;
   logic        bad;

   always_ff @(posedge clk_link or negedge rst_lnk_n)
   begin
      if (!rst_lnk_n)
      begin
         cfg_s1   <= CFG_RESET;
         lcfg     <= CFG_RESET;
         start_sr <= 3'h0;
         idle_sr  <= 3'h0;
         pin_sr   <= 2'h0;
      end
      else
      begin
         cfg_s1   <= cfg;
         lcfg     <= cfg_s1;
         start_sr <= {start_sr[1:0], start_tgl};
         idle_sr  <= {idle_sr[1:0], idle_tgl};
         pin_sr   <= {pin_sr[0], pin_zero_in};
      end
   end

   assign start_ev = start_sr[2] ^ start_sr[1];
   assign idle_ev  = idle_sr[2] ^ idle_sr[1];
   assign is_sync  = (lcfg.layout == LAYOUT_SYNC);
   assign is_async = (lcfg.layout == LAYOUT_ASYNC);
   assign bad      = is_async && (lcfg.mod_fmt == MOD_MSK);

   // ----------------------------------------------------
   // Link state machine and bit timing (clk_link)
   // ----------------------------------------------------
   stdi_state_t state;
   stdi_state_t next_state;
   logic [7:0]  div_cnt;
   logic [7:0]  next_div_cnt;
   logic [2:0]  os_ph;
   logic [2:0]  next_os_ph;
   logic [15:0] cal_cnt;
   logic [15:0] next_cal_cnt;
   logic [7:0]  hdr_cnt;
   logic [7:0]  next_hdr_cnt;
   logic [47:0] hdr_sr;
   logic [47:0] next_hdr_sr;
   logic [LATENCY_BITS-1:0] pipe;
   logic [LATENCY_BITS-1:0] next_pipe;
   logic        next_mod_data;
   logic        next_serial_clock;
   logic        os_tick;
   logic        bit_tick;
   logic        go_tx;
   logic        serial_busy;

   assign os_tick  = (div_cnt == lcfg.rate_div);
   assign bit_tick = os_tick && (os_ph == OS_LAST);

   always_comb
   begin
      next_state        = state;
      next_div_cnt      = os_tick ? 8'h00 : div_cnt + 8'h01;
      next_os_ph        = os_tick ? os_ph + 3'h1 : os_ph;
      next_cal_cnt      = cal_cnt;
      next_hdr_cnt      = hdr_cnt;
      next_hdr_sr       = hdr_sr;
      next_pipe         = pipe;
      next_mod_data     = mod_data;
      next_serial_clock = 1'b0;
      go_tx             = 1'b0;
      case (state)
         ST_IDLE:
         begin
            next_os_ph = 3'h0;
            if (start_ev && !bad && (is_sync || is_async))
            begin
               if (lcfg.auto_cal)
               begin
                  next_state   = ST_CAL;
                  next_cal_cnt = 16'h0000;
               end
               else
                  go_tx = 1'b1;
            end
         end
         ST_CAL:
         begin
            next_os_ph   = 3'h0;
            next_cal_cnt = cal_cnt + 16'h0001;
            if (cal_cnt == 16'(CAL_CYCLES - 1))
               go_tx = 1'b1;
         end
         ST_HDR:
         begin
            // Host clock held low until payload is wanted
            if (bit_tick)
            begin
               next_mod_data = hdr_sr[47];
               next_hdr_sr   = {hdr_sr[46:0], 1'b0};
               next_hdr_cnt  = hdr_cnt + 8'h01;
               if (hdr_cnt == 8'(HDR_BITS - 1))
                  next_state = ST_TX;
            end
         end
         ST_TX:
         begin
            if (is_sync)
            begin
               // High in first half: host shifts on the rise
               next_serial_clock = (next_os_ph < 3'h4);
               if (os_tick && os_ph == OS_CAPTURE)
                  next_pipe = {pipe[LATENCY_BITS-2:0],
                               pin_sr[1]};
               if (bit_tick)
                  next_mod_data = pipe[LATENCY_BITS-1];
            end
            else if (os_tick)
               next_mod_data = pin_sr[1];
         end
         default: next_state = ST_IDLE;
      endcase
      if (go_tx)
      begin
         // Restart the divider so phase zero is a full phase
         next_div_cnt = 8'h00;
         next_os_ph   = 3'h0;
         next_hdr_cnt = 8'h00;
         next_hdr_sr  = HDR_WORD << (48 - HDR_BITS);
         if (is_sync && lcfg.frame_mode != FRAME_NONE)
            next_state = ST_HDR;
         else
            next_state = ST_TX;
      end
      // First bit of a burst: raise the clock on entry, not a
      // cycle late, so every high phase has the same length
      if (next_state == ST_TX && state != ST_TX && is_sync)
         next_serial_clock = (next_os_ph < 3'h4);
      if (idle_ev || bad)
      begin
         next_state        = ST_IDLE;
         next_serial_clock = 1'b0;
      end
   end

   always_ff @(posedge clk_link or negedge rst_lnk_n)
   begin
      if (!rst_lnk_n)
      begin
         state        <= ST_IDLE;
         div_cnt      <= 8'h00;
         os_ph        <= 3'h0;
         cal_cnt      <= 16'h0000;
         hdr_cnt      <= 8'h00;
         hdr_sr       <= '0;
         pipe         <= '0;
         mod_data     <= 1'b0;
         serial_clock <= 1'b0;
      end
      else
      begin
         state        <= next_state;
         div_cnt      <= next_div_cnt;
         os_ph        <= next_os_ph;
         cal_cnt      <= next_cal_cnt;
         hdr_cnt      <= next_hdr_cnt;
         hdr_sr       <= next_hdr_sr;
         pipe         <= next_pipe;
         mod_data     <= next_mod_data;
         serial_clock <= next_serial_clock;
      end
   end

   // ----------------------------------------------------
   // Pin direction, path enables and status (clk_link)
   // ----------------------------------------------------
   // Enables are registered so every output leaves a flop.
   assign serial_busy = (next_state != ST_IDLE) &&
                        (is_sync || is_async);

   always_ff @(posedge clk_link or negedge rst_lnk_n)
   begin
      if (!rst_lnk_n)
      begin
         pin_zero_out  <= 1'b0;
         pin_zero_oe   <= 1'b1;
         synth_on      <= 1'b0;
         tx_active     <= 1'b0;
         pkt_engine_en <= 1'b1;
         fifo_path_en  <= 1'b1;
         whiten_en     <= 1'b0;
         fec_en        <= 1'b0;
         biphase_en    <= 1'b0;
         stat_lnk      <= '0;
      end
      else
      begin
         pin_zero_out  <= 1'b0;
         pin_zero_oe   <= !serial_busy;
         synth_on      <= (next_state != ST_IDLE);
         tx_active     <= (next_state == ST_HDR) ||
                          (next_state == ST_TX);
         pkt_engine_en <= !is_async;
         fifo_path_en  <= (lcfg.layout == LAYOUT_FIFO);
         whiten_en     <= lcfg.whiten && !is_async;
         fec_en        <= lcfg.fec && !is_async;
         biphase_en    <= lcfg.biphase && !is_async &&
                          !is_sync;
         stat_lnk      <= '{state: state, pin: pin_sr[1]};
      end
   end

endmodule // stdi_top

// ### rtl/stdi_pkg.sv
// Constants and carriers of the serial transmit data input block.
// Assumes an 8-bit register port and a free-running link clock.
//
// Functional notes
// - Layout select 1 gives synchronous serial mode
// - Device drives bit clock; host shifts data
// - Pin zero turns input during serial transmit
// - Eight bit periods input-to-modulator latency
// - Framing word mode selects header insertion
// - Layout select 3 modulates pin zero directly
// - Async input sampled at eight times rate
// - Async bypasses packet engine and FIFO
// - Async disables whitening, interleave, FEC, bi-phase; no interleave enable exists here
// - Minimum-shift keying with async is invalid
// - With header, device prepends; host sends payload
// - Start command 0x35, calibrate when automatic
// - Idle command 0x36 ends transmit, synth off
package stdi_pkg;

   // ----------------------------------------------------
   // Register map
   // ----------------------------------------------------
   localparam logic [5:0] ADDR_PKT_CTRL = 6'h08;
   localparam logic [5:0] ADDR_MOD_TWO  = 6'h12;
   localparam logic [5:0] ADDR_MOD_THR  = 6'h11;
   localparam logic [5:0] ADDR_RATE     = 6'h10;
   localparam logic [5:0] ADDR_AUTOCAL  = 6'h18;
   localparam logic [5:0] ADDR_STATUS   = 6'h35;
   localparam logic [5:0] ADDR_COMMAND  = 6'h3F;
   localparam logic [7:0] CMD_TX_START  = 8'h35;
   localparam logic [7:0] CMD_IDLE      = 8'h36;

   // ----------------------------------------------------
   // Field codes and reset values
   // ----------------------------------------------------
   localparam logic [1:0] LAYOUT_FIFO   = 2'h0;
   localparam logic [1:0] LAYOUT_SYNC   = 2'h1;
   localparam logic [1:0] LAYOUT_ASYNC  = 2'h3;
   localparam logic [2:0] MOD_MSK       = 3'h7;
   localparam logic [2:0] FRAME_NONE    = 3'h0;
   localparam logic [7:0] RATE_RESET    = 8'h0F;
   localparam logic [2:0] OS_LAST       = 3'h7;
   localparam logic [2:0] OS_CAPTURE    = 3'h3;
   localparam int         LATENCY_BITS  = 8;

   typedef struct packed {
      logic [1:0] layout;
      logic       whiten;
      logic       fec;
      logic [2:0] mod_fmt;
      logic       biphase;
      logic [2:0] frame_mode;
      logic [7:0] rate_div;
      logic       auto_cal;
   } stdi_cfg_t;

   localparam stdi_cfg_t CFG_RESET = '{
      layout: LAYOUT_FIFO, whiten: 1'b0, fec: 1'b0,
      mod_fmt: 3'h0, biphase: 1'b0, frame_mode: FRAME_NONE,
      rate_div: RATE_RESET, auto_cal: 1'b1};

   typedef enum logic [1:0] {
      ST_IDLE, ST_CAL, ST_HDR, ST_TX
   } stdi_state_t;

   typedef struct packed {
      logic [1:0] state;
      logic       pin;
   } stdi_stat_t;

endpackage

// ### verification/stdi_checker.sv
// Concurrent checks on the serial transmit data input block.
// Assumes it is bound to stdi_top; configuration changes while idle.
module stdi_checker
   import stdi_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic       clk_link,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       pin_zero_oe,
   input wire logic       serial_clock,
   input wire logic       synth_on,
   input wire logic       tx_active,
   input wire logic       pkt_engine_en,
   input wire logic       fifo_path_en,
   input wire logic       whiten_en,
   input wire logic       fec_en,
   input wire logic       biphase_en,
   input wire logic       cfg_invalid
);
   logic [1:0] lay;
   logic [2:0] modf;
   logic [7:0] rate;
   logic       go;
   logic       stop;

   // ----------------------------------------------------
   // Shadow of the configuration written by software
   // ----------------------------------------------------
   assign go = reg_wr && reg_addr == ADDR_COMMAND
               && reg_wdata == CMD_TX_START;
   assign stop = reg_wr && reg_addr == ADDR_COMMAND
                 && reg_wdata == CMD_IDLE;
   always_ff @(posedge clk_sys or negedge nrst)
      if (!nrst)
      begin
         lay  <= LAYOUT_FIFO;
         modf <= 3'h0;
         rate <= RATE_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_PKT_CTRL) lay <= reg_wdata[1:0];
         if (reg_addr == ADDR_MOD_TWO) modf <= reg_wdata[6:4];
         if (reg_addr == ADDR_RATE) rate <= reg_wdata;
      end

   // ----------------------------------------------------
   // Properties
   // ----------------------------------------------------
   property p_oe_busy;
      @(posedge clk_link) disable iff (!nrst)
      tx_active |-> !pin_zero_oe;
   endproperty
   a_oe_busy: assert property (p_oe_busy)
      else $error("pin driven while transmitting");
   property p_sclk_idle;
      @(posedge clk_link) disable iff (!nrst)
      !$past(tx_active) && !tx_active |-> !serial_clock;
   endproperty
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("bit clock moves while idle");
   // Shape only judged at divider 1: eight link cycles per half bit
   property p_sclk_shape;
      @(posedge clk_link) disable iff (!nrst)
      rate == 8'h01 && $rose(serial_clock)
         |-> (serial_clock || !tx_active)[*8] ##1 !serial_clock;
   endproperty
   a_sclk_shape: assert property (p_sclk_shape)
      else $error("bit clock high phase wrong");
   property p_bypass;
      @(posedge clk_sys) disable iff (!nrst)
      !pkt_engine_en |-> !fifo_path_en && !whiten_en && !fec_en;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("buffering left on in async layout");
   property p_no_code;
      @(posedge clk_sys) disable iff (!nrst)
      (lay == LAYOUT_ASYNC)[*3] |-> !biphase_en && !pkt_engine_en;
   endproperty
   a_no_code: assert property (p_no_code)
      else $error("coding left on in async layout");
   property p_start;
      @(posedge clk_sys) disable iff (!nrst)
      go && lay == LAYOUT_SYNC && !synth_on && !cfg_invalid
         |-> ##[1:12] synth_on;
   endproperty
   a_start: assert property (p_start)
      else $error("start command not taken");
   property p_fifo_refuse;
      @(posedge clk_sys) disable iff (!nrst)
      go && lay == LAYOUT_FIFO && !synth_on |-> ##1 (!synth_on)[*8];
   endproperty
   a_fifo_refuse: assert property (p_fifo_refuse)
      else $error("start taken in buffered layout");
   property p_idle_cmd;
      @(posedge clk_sys) disable iff (!nrst)
      stop |-> ##[1:12] (!synth_on && !tx_active);
   endproperty
   a_idle_cmd: assert property (p_idle_cmd)
      else $error("idle command not obeyed");
   property p_inv_set;
      @(posedge clk_sys) disable iff (!nrst)
      (lay == LAYOUT_ASYNC && modf == MOD_MSK)[*3] |-> cfg_invalid;
   endproperty
   a_inv_set: assert property (p_inv_set)
      else $error("invalid setting not flagged");
   property p_inv_off;
      @(posedge clk_sys) disable iff (!nrst)
      cfg_invalid[*8] |-> !synth_on;
   endproperty
   a_inv_off: assert property (p_inv_off)
      else $error("transmit under invalid setting");
endmodule // stdi_checker

bind stdi_top stdi_checker chk (.clk_sys, .nrst, .clk_link, .reg_addr,
   .reg_wdata, .reg_wr, .pin_zero_oe, .serial_clock, .synth_on,
   .tx_active, .pkt_engine_en, .fifo_path_en, .whiten_en, .fec_en,
   .biphase_en, .cfg_invalid);

// ### verification/stdi_host.sv
// Host model: new random NRZ bit after each rising bit clock.
// Assumes the bench sets async_mode and drives host_bit itself then.
module stdi_host
(
   input  wire logic serial_clock,
   input  wire logic pin_zero_out,
   input  wire logic pin_zero_oe,
   output logic      pin_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   logic host_bit   = 1'b0;
   bit   async_mode = 1'b0;
   bit   sent[$];

   // Level seen by both sides; device wins while enabled
   assign pin_wire = pin_zero_oe ? pin_zero_out : host_bit;

   // Plain levels only, no bi-phase; header is not ours to add
   always @(posedge serial_clock)
      if (!async_mode)
      begin
         bit b;
         b = 1'($urandom);
         host_bit <= b;
         sent.push_back(b);
      end
endmodule // stdi_host

// ### verification/test_serial_tx_data_input.sv
// Self-checking bench of the serial transmit data input block.
// Assumes stdi_pkg, stdi_top, stdi_host and the bound checker.
module test_serial_tx_data_input;
   timeunit 1ns;
   timeprecision 1ps;
   import stdi_pkg::*;
   logic        clk_sys = 1'b0;
   logic        clk_link = 1'b0;
   logic        nrst = 1'b0;
   logic  [5:0] reg_addr = 6'h00;
   logic  [7:0] reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic  [7:0] reg_rdata;
   logic        pin_wire, pin_zero_out, pin_zero_oe, serial_clock;
   logic        mod_data, synth_on, tx_active, pkt_engine_en;
   logic        fifo_path_en, whiten_en, fec_en, biphase_en, cfg_invalid;
   logic  [7:0] v;
   logic [13:0] regs [5];
   int          errors = 0, total_checks = 0, rises = 0, t;
   bit          mon_on = 1'b0, b;

   stdi_top #(.CAL_CYCLES(100), .HDR_BITS(8)) DUT (.clk_sys, .nrst,
      .clk_link, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .pin_zero_in(pin_wire), .pin_zero_out, .pin_zero_oe,
      .serial_clock, .mod_data, .synth_on, .tx_active, .pkt_engine_en,
      .fifo_path_en, .whiten_en, .fec_en, .biphase_en, .cfg_invalid);
   stdi_host host (.serial_clock, .pin_zero_out, .pin_zero_oe, .pin_wire);

   initial forever #50 clk_sys = ~clk_sys;
   initial
   begin
      #3;
      forever #6 clk_link = ~clk_link;
   end

   // ----------------------------------------------------
   // Tasks
   // ----------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask
   task stop_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Bit n on the modulator must be the host bit sent eight bits earlier
   always @(posedge serial_clock)
      if (mon_on)
      begin
         #6;
         if (rises >= LATENCY_BITS)
            check(mod_data, host.sent[rises - LATENCY_BITS]);
         rises++;
      end
   task run_sync(input logic [7:0] frame, cal, input logic [1:0] first);
      wr(ADDR_PKT_CTRL, 8'h01);
      wr(ADDR_MOD_THR, frame);
      wr(ADDR_AUTOCAL, cal);
      wr(ADDR_RATE, 8'h01);
      host.sent.delete();
      rises = 0;
      mon_on = 1'b1;
      wr(ADDR_COMMAND, CMD_TX_START);
      for (int i = 0; i < 20 && !synth_on; i++) @(posedge clk_sys);
      rd(ADDR_STATUS, v);
      check(v[1:0], first);
      check(pin_zero_oe, 1'b0);
      for (int i = 0; i < 400 && rises < 24; i++) @(posedge clk_sys);
      check(rises >= 24, 1'b1);
      rd(ADDR_STATUS, v);
      check(v[1:0], 2'h3);
      mon_on = 1'b0;
      wr(ADDR_COMMAND, CMD_IDLE);
      repeat (12) @(posedge clk_sys);
      check({synth_on, tx_active, serial_clock, pin_zero_oe}, 4'h1);
   endtask

   // ----------------------------------------------------
   // Main sequence
   // ----------------------------------------------------
   initial
   begin
      void'($urandom(30));
      regs = '{{ADDR_RATE, RATE_RESET}, {ADDR_AUTOCAL, 8'h01},
               {ADDR_PKT_CTRL, 8'h00}, {ADDR_COMMAND, 8'h00},
               {6'h2A, 8'h00}};
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      foreach (regs[i])
      begin
         rd(regs[i][13:8], v);
         check(v, regs[i][7:0]);
      end
      wr(ADDR_COMMAND, CMD_TX_START);
      repeat (10) @(posedge clk_sys);
      check(synth_on, 1'b0);
      run_sync(8'h00, 8'h00, 2'h3);
      run_sync(8'h01, 8'h00, 2'h2);
      run_sync(8'h00, 8'h01, 2'h1);
      rd(ADDR_RATE, v);
      check(v, 8'h01);
      t = $urandom_range(3);
      wr(ADDR_RATE, 8'(t));
      wr(ADDR_PKT_CTRL, 8'h47);
      wr(ADDR_MOD_TWO, 8'h08);
      wr(ADDR_AUTOCAL, 8'h00);
      repeat (4) @(posedge clk_sys);
      check({pkt_engine_en, fifo_path_en, whiten_en, fec_en, biphase_en},
            5'h00);
      host.async_mode = 1'b1;
      wr(ADDR_COMMAND, CMD_TX_START);
      for (int i = 0; i < 20 && !tx_active; i++) @(posedge clk_sys);
      t = 96 * (t + 1);
      repeat (16)
      begin
         b = 1'($urandom);
         host.host_bit = b;
         #(t * 3 / 4);
         check(mod_data, b);
         #(t - t * 3 / 4);
      end
      wr(ADDR_COMMAND, CMD_IDLE);
      repeat (12) @(posedge clk_sys);
      wr(ADDR_MOD_TWO, 8'h70);
      repeat (4) @(posedge clk_sys);
      check(cfg_invalid, 1'b1);
      rd(ADDR_STATUS, v);
      check(v[3], 1'b1);
      wr(ADDR_COMMAND, CMD_TX_START);
      repeat (10) @(posedge clk_sys);
      check(synth_on, 1'b0);
      stop_test();
   end

   initial
   begin
      #200000;
      errors++;
      stop_test();
   end
endmodule // test_serial_tx_data_input
